/* test/mem_model.sv */
// memory model: one coherent shared copy behind the unit
`timescale 1ns/1ps
`default_nettype none

module mem_model
(
	input  wire logic                    clock,      // core clock
	input  wire logic                    rst_n,      // async, active low
	input  wire logic                    mem_valid,  // request from unit
	input  wire lsu_order_pkg::mem_req_t mem_req,    // request payload
	output logic                         mem_ready,  // request taken
	output logic                         mem_rvalid, // load data pulse
	output logic [31:0]                  mem_rdata,  // load data
	input  wire logic                    stall,      // hold stores back
	input  wire logic                    slow        // long load latency
);
	logic [31:0]             word [0:15]; // shared image
	lsu_order_pkg::mem_req_t log_q [$];   // accepted requests in order
	logic [2:0]              cnt;         // load latency countdown
	logic [3:0]              raddr;       // pending load word

	initial for (int i = 0; i < 16; i++) word[i] = 32'hC0DE0000 + i;

	// loads are always taken at once; only stores can be held back
	assign mem_ready = !(stall && mem_req.is_store);

	// ----------------------------------------------------------------
	// accept, commit and answer
	// ----------------------------------------------------------------
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt        <= 3'h0;
			mem_rvalid <= 1'b0;
			mem_rdata  <= 32'h0;
		end
		else
		begin
			mem_rvalid <= 1'b0;
			mem_rdata  <= ~mem_rdata; // inverted each cycle between pulses, so the old answer shows again every second cycle
			if (cnt == 3'h1)
			begin
				mem_rvalid <= 1'b1;
				mem_rdata  <= word[raddr];
			end
			if (cnt != 3'h0)
				cnt <= cnt - 3'h1;
			if (mem_valid && mem_ready)
			begin
				log_q.push_back(mem_req);
				if (mem_req.is_store)
					word[mem_req.addr[3:0]] <= mem_req.data;
				else
				begin
					cnt   <= slow ? 3'h4 : 3'h1;
					raddr <= mem_req.addr[3:0];
				end
			end
		end
	end
endmodule : mem_model

`default_nettype wire

/* test/testbench.sv */
// self-checking testbench for the load/store ordering unit
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                     clock, rst_n, req_valid, ld_ack;   // driven here
	lsu_order_pkg::core_req_t req;                               // access payload
	logic                     req_ready, ld_valid, ld_forwarded; // unit status
	logic [31:0]              ld_data, mem_rdata;                // data returns
	logic                     mem_valid, mem_ready, mem_rvalid;  // memory side
	lsu_order_pkg::mem_req_t  mem_req;                           // memory payload
	logic                     sb_empty, sb_full, stall, slow;    // buffer, model knobs
	logic [31:0]              shadow [0:15];                     // program-order image
	int                       bad_count, tests_run;              // tallies

	load_store_ordering_unit i_dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .ld_valid(ld_valid), .ld_data(ld_data),
		.ld_forwarded(ld_forwarded), .ld_ack(ld_ack), .mem_valid(mem_valid),
		.mem_req(mem_req), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata), .sb_empty(sb_empty), .sb_full(sb_full));
	mem_model i_mem (.clock(clock), .rst_n(rst_n), .mem_valid(mem_valid),
		.mem_req(mem_req), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata), .stall(stall), .slow(slow));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	// a wait that ran out counts as a mismatch and ends the run
	task automatic give_up(input string what);
		$display("wrong value %s expected high seen timeout", what);
		bad_count++;
		report_and_stop();
	endtask : give_up

	// request held from a falling edge until the edge that takes it
	task automatic do_req(input logic st, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(negedge clock);
		req_valid = 1'b1;
		req       = {st, a, d};
		#1; // let req_ready settle on the new request before looking
		for (n = 0; n < 50 && req_ready !== 1'b1; n++)
			@(negedge clock);
		if (n == 50)
			give_up("req_ready");
		if (st)
			shadow[a[3:0]] = d;
		@(negedge clock);
		req_valid = 1'b0;
	endtask : do_req

	task automatic do_load(input logic [31:0] a, input logic fwd);
		int n;
		do_req(1'b0, a, 32'h0);
		for (n = 0; n < 50 && ld_valid !== 1'b1; n++)
			@(negedge clock);
		if (n == 50)
			give_up("ld_valid");
		check("ld_data", shadow[a[3:0]], ld_data);
		check("ld_forwarded", {31'h0, fwd}, {31'h0, ld_forwarded});
		ld_ack = 1'b1;
		@(negedge clock);
		ld_ack = 1'b0;
	endtask : do_load

	task automatic wait_empty;
		int n;
		for (n = 0; n < 50 && sb_empty !== 1'b1; n++)
			@(negedge clock);
		if (n == 50)
			give_up("sb_empty");
	endtask : wait_empty

	task automatic check_log(input int i, input logic st, input logic [30:0] a);
		check("log", {st, a}, {i_mem.log_q[i].is_store, i_mem.log_q[i].addr[30:0]});
	endtask : check_log

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_drain;
		stall = 1'b1;
		i_mem.log_q.delete();
		for (int i = 1; i < 5; i++)
			do_req(1'b1, i, 32'h5100 + i);
		check("sb_full", 32'h1, {31'h0, sb_full});
		@(negedge clock);
		req_valid = 1'b1;
		req       = {1'b1, 32'h5, 32'h5105};
		repeat (3) @(negedge clock);
		check("req_ready", 32'h0, {31'h0, req_ready});
		check("word1", 32'hC0DE0001, i_mem.word[1]);
		req_valid = 1'b0;
		stall     = 1'b0;
		wait_empty();
		for (int i = 0; i < 4; i++)
			check_log(i, 1'b1, 31'(i + 1));
		check("word4", 32'h5104, i_mem.word[4]);
		$display("test drain done");
	endtask : t_drain

	// later loads see buffered stores; other processors do not
	task automatic t_forward;
		stall = 1'b1;
		do_req(1'b1, 32'h6, 32'h6601);
		do_req(1'b1, 32'h6, 32'h6602);
		do_req(1'b1, 32'h7, 32'h7701);
		do_load(32'h6, 1'b1);
		check("word6", 32'hC0DE0006, i_mem.word[6]);
		do_load(32'h8, 1'b0);
		stall = 1'b0;
		wait_empty();
		check("word6", 32'h6602, i_mem.word[6]);
		$display("test forward done");
	endtask : t_forward

	// slow memory must not let loads overtake one another
	task automatic t_loads;
		int la [3] = '{2, 9, 3};
		slow = 1'b1;
		i_mem.log_q.delete();
		for (int i = 0; i < 3; i++)
			do_load(la[i], 1'b0);
		for (int i = 0; i < 3; i++)
			check_log(i, 1'b0, 31'(la[i]));
		$display("test loads done");
	endtask : t_loads

	task automatic t_load_store;
		i_mem.log_q.delete();
		do_load(32'hA, 1'b0);
		do_req(1'b1, 32'hB, 32'hBB01);
		do_req(1'b1, 32'hA, 32'hAA01);
		wait_empty();
		check_log(0, 1'b0, 31'hA);
		check_log(1, 1'b1, 31'hB);
		check_log(2, 1'b1, 31'hA);
		$display("test load store done");
	endtask : t_load_store

	// ----------------------------------------------------------------
	// clock, reset and sequence
	// ----------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	initial
	begin
		{rst_n, req_valid, ld_ack, stall, slow} = 5'h0;
		req       = '0;
		bad_count = 0;
		tests_run = 0;
		for (int i = 0; i < 16; i++)
			shadow[i] = 32'hC0DE0000 + i;
		repeat (16) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		check("sb_empty", 32'h1, {31'h0, sb_empty});
		check("ld_valid", 32'h0, {31'h0, ld_valid});
		t_drain();
		t_forward();
		t_loads();
		t_load_store();
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire

/* verilog/load_store_ordering_unit.sv */
// load/store ordering unit with store buffer and forwarding
`timescale 1ns/1ps
`default_nettype none

module load_store_ordering_unit
(
	input  wire logic                           clock,         // 40 MHz core clock
	input  wire logic                           rst_n,         // async, active low
	input  wire logic                           req_valid,     // core access offered
	input  wire lsu_order_pkg::core_req_t       req,           // access payload
	output logic                                req_ready,     // access accepted
	output logic                                ld_valid,      // load answer valid
	output logic [lsu_order_pkg::DATA_W-1:0]    ld_data,       // load answer data
	output logic                                ld_forwarded,  // answer came from buffer
	input  wire logic                           ld_ack,        // core took the answer
	output logic                                mem_valid,     // memory request valid
	output lsu_order_pkg::mem_req_t             mem_req,       // memory request payload
	input  wire logic                           mem_ready,     // memory took request
	input  wire logic                           mem_rvalid,    // load data returned
	input  wire logic [lsu_order_pkg::DATA_W-1:0] mem_rdata,   // returned data
	output logic                                sb_empty,      // nothing buffered
	output logic                                sb_full        // buffer full
);

	// ----------------------------------------------------------------
	// storage and state
	// ----------------------------------------------------------------
	lsu_order_pkg::sb_entry_t                sb_mem [lsu_order_pkg::SB_DEPTH]; // slots
	logic [lsu_order_pkg::SB_DEPTH-1:0]      sb_vld;        // slot holds a store
	logic [lsu_order_pkg::SB_PTR_W-1:0]      head;          // oldest store
	logic [lsu_order_pkg::SB_PTR_W-1:0]      tail;          // next free slot
	logic [lsu_order_pkg::SB_CNT_W-1:0]      count;         // occupancy
	lsu_order_pkg::ld_state_t                ld_state;      // load engine
	logic [lsu_order_pkg::ADDR_W-1:0]        ld_addr;       // load in flight

	logic [lsu_order_pkg::SB_PTR_W-1:0]      next_head;
	logic [lsu_order_pkg::SB_PTR_W-1:0]      next_tail;
	logic [lsu_order_pkg::SB_CNT_W-1:0]      next_count;
	lsu_order_pkg::ld_state_t                next_ld_state;
	logic [lsu_order_pkg::ADDR_W-1:0]        next_ld_addr;
	logic [lsu_order_pkg::DATA_W-1:0]        next_ld_data;
	logic                                    next_ld_forwarded;

	logic fwd_hit;                                          // buffered match found
	logic [lsu_order_pkg::DATA_W-1:0] fwd_data;             // youngest match data
	logic take_store;                                       // store enters buffer
	logic take_load;                                        // load accepted
	logic load_to_mem;                                      // load goes to memory
	logic drain;                                            // head committed
	logic sel_load;                                         // memory port used by load

	// ----------------------------------------------------------------
	// forwarding search
	// ----------------------------------------------------------------
	// walk oldest to youngest so the youngest matching store wins
	function automatic logic [lsu_order_pkg::DATA_W:0] search
	(
		input logic [lsu_order_pkg::ADDR_W-1:0] a
	);
		logic [lsu_order_pkg::DATA_W:0]     r;
		logic [lsu_order_pkg::SB_PTR_W-1:0] idx;
		r = '0;
		for (int i = 0; i < lsu_order_pkg::SB_DEPTH; i++)
		begin
			idx = head + i[lsu_order_pkg::SB_PTR_W-1:0];
			if (sb_vld[idx] && sb_mem[idx].addr == a)
				r = {1'b1, sb_mem[idx].data};
		end
		return r;
	endfunction : search

	// match for the offered load address
	always_comb
	begin
		{fwd_hit, fwd_data} = search(req.addr);
	end

	// ----------------------------------------------------------------
	// acceptance and memory port arbitration
	// ----------------------------------------------------------------
	// one load at a time keeps loads in order; a store only enters
	// when no load is outstanding, so it cannot drain before an
	// older load obtained its value
	always_comb
	begin
		// full at the documented depth; the count never passes it
		sb_full     = (count == lsu_order_pkg::SB_CNT_W'(lsu_order_pkg::SB_DEPTH));
		sb_empty    = (count == lsu_order_pkg::CNT_RESET);
		req_ready   = (ld_state == lsu_order_pkg::LD_IDLE) &&
		              (!req.is_store || !sb_full);
		take_store  = req_valid && req_ready && req.is_store;
		take_load   = req_valid && req_ready && !req.is_store;
		// load to a different address goes ahead of buffered stores
		load_to_mem = take_load && !fwd_hit;
		sel_load    = load_to_mem;
		// buffered stores reach memory only from the head, in order
		mem_valid   = sel_load || !sb_empty;
		if (sel_load)
		begin
			mem_req = '{is_store: 1'b0, addr: req.addr, data: '0};
		end
		else
		begin
			mem_req = '{is_store: 1'b1, addr: sb_mem[head].addr,
			            data: sb_mem[head].data};
		end
		drain       = !sel_load && !sb_empty && mem_ready;
	end

	// ----------------------------------------------------------------
	// store buffer pointers
	// ----------------------------------------------------------------
	// pointers move on a take and on a commit; both may fall in one
	// cycle. limitation: a missing load is offered to memory only in
	// its accept cycle and is never retried, so memory must take loads
	// at once
	always_comb
	begin
		next_head  = head;
		next_tail  = tail;
		next_count = count;
		if (drain)
		begin
			next_head = head + 2'h1;
		end
		if (take_store)
		begin
			next_tail = tail + 2'h1;
		end
		next_count = count + {2'h0, take_store} - {2'h0, drain};
	end

	// registers of the store buffer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			head   <= lsu_order_pkg::PTR_RESET;
			tail   <= lsu_order_pkg::PTR_RESET;
			count  <= lsu_order_pkg::CNT_RESET;
			sb_vld <= '0;
		end
		else
		begin
			head  <= next_head;
			tail  <= next_tail;
			count <= next_count;
			if (drain)
				sb_vld[head] <= 1'b0;
			if (take_store)
				sb_vld[tail] <= 1'b1;
		end
	end

	// slot payloads need no reset
	always_ff @(posedge clock)
	begin
		if (take_store)
			sb_mem[tail] <= '{addr: req.addr, data: req.data};
	end

	// ----------------------------------------------------------------
	// load engine
	// ----------------------------------------------------------------
	always_comb
	begin
		next_ld_state     = ld_state;
		next_ld_addr      = ld_addr;
		next_ld_data      = ld_data;
		next_ld_forwarded = ld_forwarded;
		unique case (ld_state)
			lsu_order_pkg::LD_IDLE:
			begin
				if (take_load && fwd_hit)
				begin
					// answered from the buffer, never from memory
					next_ld_state     = lsu_order_pkg::LD_DONE;
					next_ld_data      = fwd_data;
					next_ld_forwarded = 1'b1;
				end
				else if (load_to_mem)
				begin
					next_ld_state     = lsu_order_pkg::LD_WAIT;
					next_ld_addr      = req.addr;
					next_ld_forwarded = 1'b0;
				end
			end
			lsu_order_pkg::LD_WAIT:
			begin
				// load must have been taken; memory answers later
				if (mem_rvalid)
				begin
					next_ld_state = lsu_order_pkg::LD_DONE;
					next_ld_data  = mem_rdata;
				end
			end
			lsu_order_pkg::LD_DONE:
			begin
				if (ld_ack)
					next_ld_state = lsu_order_pkg::LD_IDLE;
			end
			default:
			begin
				next_ld_state = lsu_order_pkg::LD_IDLE;
			end
		endcase
	end

	// registers of the load engine
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ld_state     <= lsu_order_pkg::LD_IDLE;
			ld_addr      <= '0;
			ld_data      <= '0;
			ld_forwarded <= 1'b0;
		end
		else
		begin
			ld_state     <= next_ld_state;
			ld_addr      <= next_ld_addr;
			ld_data      <= next_ld_data;
			ld_forwarded <= next_ld_forwarded;
		end
	end

	assign ld_valid = (ld_state == lsu_order_pkg::LD_DONE);

	// no cross-processor ordering is imposed here; a store
	// leaves only after older loads finished, so causality holds
	// provided the shared memory system is coherent.

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_store_taken;
		take_store && !sel_load;
	endsequence

	AST_LOAD_ONE_AT_A_TIME: assert property (@(posedge clock) disable iff (!rst_n)
		ld_state != lsu_order_pkg::LD_IDLE |-> !req_ready)
		else $error("load accepted while another load pending");

	AST_DRAIN_FROM_HEAD: assert property (@(posedge clock) disable iff (!rst_n)
		(mem_valid && mem_req.is_store) |->
		(mem_req.addr == sb_mem[head].addr && sb_vld[head]))
		else $error("store issued out of order");

	AST_NO_STORE_DURING_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
		ld_state == lsu_order_pkg::LD_WAIT |-> !take_store)
		else $error("store entered before older load done");

	AST_MISS_GOES_TO_MEM: assert property (@(posedge clock) disable iff (!rst_n)
		(take_load && !fwd_hit) |-> (mem_valid && !mem_req.is_store))
		else $error("missing load not issued");

	AST_HIT_NOT_TO_MEM: assert property (@(posedge clock) disable iff (!rst_n)
		(take_load && fwd_hit) |-> ##1 (ld_valid && ld_forwarded))
		else $error("same-address load bypassed buffer");

	AST_FWD_DATA: assert property (@(posedge clock) disable iff (!rst_n)
		(take_load && fwd_hit) |-> ##1 (ld_data == $past(fwd_data)))
		else $error("forwarded data wrong");

	AST_STORE_INVISIBLE: assert property (@(posedge clock) disable iff (!rst_n)
		s_store_taken |-> ##1 (count != lsu_order_pkg::CNT_RESET))
		else $error("taken store lost before commit");

	AST_ONE_DRAIN: assert property (@(posedge clock) disable iff (!rst_n)
		drain |-> ##1 (head == $past(head) + 2'h1))
		else $error("drain did not advance head by one");

	// a miss is issued in its accept cycle, waits, then takes the data
	sequence s_miss_issue;
		load_to_mem;
	endsequence

	sequence s_miss_return;
		(ld_state == lsu_order_pkg::LD_WAIT) && mem_rvalid;
	endsequence

	// later accesses stay out while a miss is in memory
	AST_MISS_BLOCKS_CORE: assert property (@(posedge clock) disable iff (!rst_n)
		s_miss_issue |=> (ld_state == lsu_order_pkg::LD_WAIT && !req_ready))
		else $error("missing load did not block later accesses");

	// the memory answer is what the core sees, never buffer data
	AST_MISS_ANSWER: assert property (@(posedge clock) disable iff (!rst_n)
		s_miss_return |=> (ld_valid && !ld_forwarded && ld_data == $past(mem_rdata)))
		else $error("memory answer not handed to core");

	// an answer stands unchanged until the core takes it
	AST_ANSWER_STANDS: assert property (@(posedge clock) disable iff (!rst_n)
		(ld_valid && !ld_ack) |=> (ld_valid && $stable(ld_data)))
		else $error("load answer changed before it was taken");

	// a full buffer refuses stores so no slot is overwritten
	AST_FULL_REFUSES_STORE: assert property (@(posedge clock) disable iff (!rst_n)
		(sb_full && req.is_store) |-> !req_ready)
		else $error("store accepted into a full buffer");

	// occupancy and slot flags must agree at the head
	AST_HEAD_HELD: assert property (@(posedge clock) disable iff (!rst_n)
		!sb_empty |-> sb_vld[head])
		else $error("occupied buffer has no store at its head");

	// no store request reaches memory unless one is buffered
	AST_NO_PHANTOM_STORE: assert property (@(posedge clock) disable iff (!rst_n)
		(sb_empty && !sel_load) |-> !mem_valid)
		else $error("store request with nothing buffered");

	// occupancy never exceeds the slot count
	AST_COUNT_BOUND: assert property (@(posedge clock) disable iff (!rst_n)
		count <= lsu_order_pkg::SB_CNT_W'(lsu_order_pkg::SB_DEPTH))
		else $error("buffer occupancy beyond depth");

endmodule : load_store_ordering_unit

`default_nettype wire

/* verilog/lsu_order_pkg.sv */
// constants and carrier types for the load/store ordering unit
package lsu_order_pkg;

	// ----------------------------------------------------------------
	// widths and depths
	// ----------------------------------------------------------------
	localparam int ADDR_W   = 32;               // word address width
	localparam int DATA_W   = 32;               // one aligned word
	localparam int SB_DEPTH = 4;                // store buffer entries
	localparam int SB_PTR_W = 2;                // index width
	localparam int SB_CNT_W = 3;                // occupancy width

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [SB_CNT_W-1:0] CNT_RESET = 3'h0;
	localparam logic [SB_PTR_W-1:0] PTR_RESET = 2'h0;

	// core request: one program-ordered access
	typedef struct packed {
		logic              is_store;             // 1 store, 0 load
		logic [ADDR_W-1:0] addr;                 // word address
		logic [DATA_W-1:0] data;                 // store data
	} core_req_t;

	// memory-side request
	typedef struct packed {
		logic              is_store;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mem_req_t;

	// one store buffer slot
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} sb_entry_t;

	// load engine states, one-hot
	typedef enum logic [2:0] {
		LD_IDLE = 3'h1,                          // no load outstanding
		LD_WAIT = 3'h2,                          // load in memory
		LD_DONE = 3'h4                           // answer held for core
	} ld_state_t;

endpackage : lsu_order_pkg
